// file: logic/cfg_word_decoder.sv
// configuration word decoder: latches the two nonvolatile words when reset
// is released and drives decoded settings to watchdog, usb and pin logic.
// assumes the nonvolatile words are stable static levels from storage.
// limitation: the postscale ratio is only a divider select; the watchdog
// counter itself lives elsewhere and just reads these levels.
// the register bus is a small axi4-lite slave with one write and one read
// in flight; a write lands one cycle after both of its halves are held and no response waits.
//
// Contract
// - window size field decodes to four percentages
// - hard enable forces watchdog on, blocks software
// - window disable bit picks non-window mode
// - postscale field gives ratio two to code
// - codes above range act as maximum code
// - bit 31 gives bus power pin owner
// - bit 30 gives usb ident pin owner
// - pin map lock permits one change only
// - module disable lock permits one change
// - 16-bit user identifier kept and readable
`default_nettype none
module cfg_word_decoder #(
  parameter int map_width = 16, // pin map setting width
  parameter int mod_width = 16 // module disable setting width
) (
  // clock and synchronous reset
  input wire logic aclk,
  input wire logic aresetn,
  // stored configuration words, static while running
  input wire logic [31:0] nv_wdog_word,
  input wire logic [31:0] nv_pin_word,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address and data
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded watchdog settings
  output logic [1:0] wdog_window_size,
  output logic wdog_enable,
  output logic wdog_window_mode,
  output logic [4:0] wdog_postscale_sel,
  output logic [20:0] wdog_post_ratio,
  // decoded pin ownership, software settings and identifier
  output logic bus_power_pin_owner,
  output logic usb_id_pin_owner,
  output logic [map_width-1:0] pin_map,
  output logic [mod_width-1:0] module_off,
  output logic [15:0] user_identifier
);

  // phases of the capture sequence
  typedef enum logic [1:0] {
    st_reset = 2'b00, // held in reset, images erased
    st_load = 2'b01, // second cycle after release, sample words
    st_run = 2'b10 // words frozen until next reset
  } phase_type;
  // the fourth code never occurs; if it did, the default restarts capture

  // whole module state in one packed struct, so the reset branch sets
  // every field at once and none can be forgotten
  typedef struct packed {
    phase_type phase;
    logic [31:0] wdog_word; // captured first word
    logic [31:0] pin_word; // captured third word
    logic sw_wdog_on; // software watchdog request
    logic map_used; // pin map already changed once
    logic mod_used; // module disable already changed once
    logic [map_width-1:0] pin_map;
    logic [mod_width-1:0] module_off;
    logic [1:0] win_size;
    logic wdog_en;
    logic win_mode;
    logic [4:0] post_sel;
    logic [20:0] post_ratio;
    logic bus_owner;
    logic id_owner;
    logic [15:0] uid;
    logic aw_held; // write address taken, awaiting data
    logic [7:0] aw_addr;
    logic w_held; // write data taken, awaiting address
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

  // registered state and its next value
  state_type state_reg;
  state_type state_next;
  // helpers of the next-state logic, given values at its top
  logic [4:0] post_eff; // postscale code after clamp
  logic wr_go; // both write halves present
  logic [31:0] wr_merged; // write data with byte lanes applied
  logic [7:0] wr_addr;

  // byte-lane merge helper for the write data
  // lanes whose strobe is low keep their old contents
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // next-state logic
  always_comb begin
    state_next = state_reg;
    post_eff = 5'h00;
    wr_go = 1'b0;
    wr_addr = 8'h00;
    wr_merged = 32'h00000000;
    // capture sequence: reset, one load cycle, then frozen
    case (state_reg.phase)
      st_reset: begin
        // one idle cycle so the words settle after release
        state_next.phase = st_load;
      end
      st_load: begin
        // sample the words exactly once per reset
        state_next.wdog_word = nv_wdog_word;
        state_next.pin_word = nv_pin_word & cfg_word_pkg::pin_word_mask;
        state_next.phase = st_run;
      end
      st_run: begin
        // nothing moves until the next reset
        state_next.phase = st_run;
      end
      default: begin
        // unreachable code: restart the capture
        state_next.phase = st_reset;
      end
    endcase

    // decode from the captured images; static once running, but the enable also follows software
    state_next.win_size = state_reg.wdog_word[cfg_word_pkg::win_size_hi:
                                              cfg_word_pkg::win_size_lo];
    // a hard enable overrides any software request
    state_next.wdog_en = state_reg.wdog_word[cfg_word_pkg::hard_en_bit]
                         | state_reg.sw_wdog_on;
    // disable bit set means non-window mode, so window mode is inverse
    state_next.win_mode =
      ~state_reg.wdog_word[cfg_word_pkg::win_dis_bit];
    post_eff = state_reg.wdog_word[cfg_word_pkg::post_hi:
                                   cfg_word_pkg::post_lo];
    // reserved codes above the top entry act as the top entry, so the
    // watchdog never gets a shorter period than the largest legal one
    if (post_eff > cfg_word_pkg::post_max_code) begin
      post_eff = cfg_word_pkg::post_max_code;
    end
    state_next.post_sel = post_eff;
    // one-hot power of two; the width covers the top code exactly
    state_next.post_ratio = 21'h000001 << post_eff;
    // pin ownership and identifier come straight from the third word
    state_next.bus_owner =
      state_reg.pin_word[cfg_word_pkg::bus_pwr_bit];
    state_next.id_owner =
      state_reg.pin_word[cfg_word_pkg::usb_id_bit];
    state_next.uid = state_reg.pin_word[cfg_word_pkg::uid_hi:
                                        cfg_word_pkg::uid_lo];

    // write channel: take address and data in either order
    state_next.awready = 1'b0;
    state_next.wready = 1'b0;
    // a half taken here waits in its holder for its partner
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    // the response leaves once the master has seen it
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // the write lands only once no earlier response is still waiting
    wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    wr_addr = state_reg.aw_addr;
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = cfg_word_pkg::resp_okay;
      // map decode on the word address; the two low bits are ignored
      case ({wr_addr[7:2], 2'b00})
        cfg_word_pkg::wdog_ctrl_off: begin
          // software may switch on; off is ignored under hard enable
          if (state_reg.w_strb[0]) begin
            state_next.sw_wdog_on = state_reg.w_data[0];
          end
        end
        cfg_word_pkg::pin_map_ctrl_off: begin
          // second change refused once locked and used
          if (!(state_reg.pin_word[cfg_word_pkg::pin_lock_bit]
                && state_reg.map_used)) begin
            wr_merged = lane_merge(32'(state_reg.pin_map),
                                   state_reg.w_data, state_reg.w_strb);
            state_next.pin_map = wr_merged[map_width-1:0];
            state_next.map_used = 1'b1;
          end else begin
            state_next.bresp = cfg_word_pkg::resp_slverr;
          end
        end
        cfg_word_pkg::module_off_ctrl_off: begin
          // same one-shot lock for the module disable word
          if (!(state_reg.pin_word[cfg_word_pkg::mod_lock_bit]
                && state_reg.mod_used)) begin
            wr_merged = lane_merge(32'(state_reg.module_off),
                                   state_reg.w_data, state_reg.w_strb);
            state_next.module_off = wr_merged[mod_width-1:0];
            state_next.mod_used = 1'b1;
          end else begin
            state_next.bresp = cfg_word_pkg::resp_slverr;
          end
        end
        cfg_word_pkg::wdog_word_off,
        cfg_word_pkg::pin_word_off,
        cfg_word_pkg::wdog_status_off,
        cfg_word_pkg::lock_status_off: begin
          // read-only images and status: writes accepted and dropped
          state_next.bresp = cfg_word_pkg::resp_okay;
        end
        default: begin
          state_next.bresp = cfg_word_pkg::resp_slverr;
        end
      endcase
    end
    // accept a new half only while its holder is empty
    state_next.awready = !state_next.aw_held && !state_reg.awready;
    state_next.wready = !state_next.w_held && !state_reg.wready;

    // read channel: one read in flight
    state_next.arready = 1'b0;
    // a finished read frees the channel
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = cfg_word_pkg::resp_okay;
      // readback: narrow fields sit in the low bits, the rest reads 0
      case ({s_axi_araddr[7:2], 2'b00})
        cfg_word_pkg::wdog_word_off: begin
          state_next.rdata = state_reg.wdog_word;
        end
        cfg_word_pkg::pin_word_off: begin
          state_next.rdata = state_reg.pin_word;
        end
        cfg_word_pkg::wdog_status_off: begin
          // status: postscale code, mode, enable, running flag
          state_next.rdata = {24'h000000, state_reg.post_sel,
                              state_reg.win_mode, state_reg.wdog_en,
                              state_reg.phase == st_run};
        end
        cfg_word_pkg::wdog_ctrl_off: begin
          state_next.rdata = {31'h00000000, state_reg.sw_wdog_on};
        end
        cfg_word_pkg::pin_map_ctrl_off: begin
          state_next.rdata = 32'(state_reg.pin_map);
        end
        cfg_word_pkg::module_off_ctrl_off: begin
          state_next.rdata = 32'(state_reg.module_off);
        end
        cfg_word_pkg::lock_status_off: begin
          state_next.rdata = {30'h00000000, state_reg.mod_used,
                              state_reg.map_used};
        end
        default: begin
          state_next.rdata = 32'h00000000;
          state_next.rresp = cfg_word_pkg::resp_slverr;
        end
      endcase
    end
    // arready drops for the take cycle and while the answer stands
    state_next.arready = !state_next.rvalid && !state_reg.arready
                         && !(s_axi_arvalid && state_reg.arready);
  end

  // state register with synchronous reset; the erased image is all ones,
  // so from release until capture the decode shows hard enable, non-window mode and the top postscale code; under reset it reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.phase <= st_reset;
      state_reg.wdog_word <= cfg_word_pkg::word_reset;
      // unimplemented bits of the third word stay zero even when erased
      state_reg.pin_word <= cfg_word_pkg::word_reset
                            & cfg_word_pkg::pin_word_mask;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register; no output passes a gate,
  // so consumers see clean levels that change only on a clock edge
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign wdog_window_size = state_reg.win_size;
  assign wdog_enable = state_reg.wdog_en;
  assign wdog_window_mode = state_reg.win_mode;
  assign wdog_postscale_sel = state_reg.post_sel;
  assign wdog_post_ratio = state_reg.post_ratio;
  assign bus_power_pin_owner = state_reg.bus_owner;
  assign usb_id_pin_owner = state_reg.id_owner;
  assign pin_map = state_reg.pin_map;
  assign module_off = state_reg.module_off;
  assign user_identifier = state_reg.uid;

endmodule
`default_nettype wire

// file: logic/cfg_word_pkg.sv
// package for the configuration word decoder: register offsets, field
// positions and reset values shared by the design and its bench.
// assumes a 32-bit axi4-lite register bus with word-aligned offsets.
`default_nettype none
package cfg_word_pkg;
  // register byte offsets
  localparam logic [7:0] wdog_word_off = 8'h00; // first config word image
  localparam logic [7:0] pin_word_off = 8'h04; // third config word image
  localparam logic [7:0] wdog_status_off = 8'h08; // live watchdog state
  localparam logic [7:0] wdog_ctrl_off = 8'h0C; // software watchdog enable
  localparam logic [7:0] pin_map_ctrl_off = 8'h10; // pin map write port
  localparam logic [7:0] module_off_ctrl_off = 8'h14; // module disable port
  localparam logic [7:0] lock_status_off = 8'h18; // lock state readback
  // field positions of the first word
  localparam int win_size_hi = 25;
  localparam int win_size_lo = 24;
  localparam int hard_en_bit = 23;
  localparam int win_dis_bit = 22;
  localparam int post_hi = 20;
  localparam int post_lo = 16;
  // field positions of the third word
  localparam int bus_pwr_bit = 31;
  localparam int usb_id_bit = 30;
  localparam int pin_lock_bit = 29;
  localparam int mod_lock_bit = 28;
  localparam int uid_hi = 15;
  localparam int uid_lo = 0;
  // postscale codes
  localparam logic [4:0] post_max_code = 5'h14;
  // window size encodings as quarter-eighths of the period
  localparam logic [1:0] win_25 = 2'h3;
  localparam logic [1:0] win_37 = 2'h2;
  localparam logic [1:0] win_50 = 2'h1;
  localparam logic [1:0] win_75 = 2'h0;
  // unimplemented bits of the third word read as zero
  localparam logic [31:0] pin_word_mask = 32'hF000FFFF;
  // erased (all ones) reset images before the first capture
  localparam logic [31:0] word_reset = 32'hFFFFFFFF;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage
`default_nettype wire

// file: bench/cfg_nv_store_model.sv
// storage model: the two nonvolatile words as the programming tool left them.
// assumes the bench only reprograms them while the device is held in reset.
`default_nettype none
module cfg_nv_store_model (
  output logic [31:0] wdog_word,
  output logic [31:0] pin_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // erased storage reads all ones until the tool programs it
  initial begin
    wdog_word = 32'hFFFFFFFF;
    pin_word = 32'hFFFFFFFF;
  end
  // programming port: both words are written whole, never bit by bit
  task automatic program_words(input logic [31:0] w1, input logic [31:0] w3);
    wdog_word = w1;
    pin_word = w3;
  endtask
endmodule
`default_nettype wire

// file: bench/cfg_word_decoder_props.sv
// checker: decoded settings against the stored words once decode settles.
// assumes the stored words change only while reset is held.
`default_nettype none
module cfg_word_decoder_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] nv_wdog_word,
  input wire logic [31:0] nv_pin_word,
  input wire logic [1:0] wdog_window_size,
  input wire logic wdog_enable,
  input wire logic wdog_window_mode,
  input wire logic [4:0] wdog_postscale_sel,
  input wire logic [20:0] wdog_post_ratio,
  input wire logic bus_power_pin_owner,
  input wire logic usb_id_pin_owner,
  input wire logic [15:0] user_identifier
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] up_reg; // edges since release, saturating
  logic ok; // decode has settled, capture plus one stage
  // count edges out of reset; during the first three the images still load
  always_ff @(posedge aclk) begin
    if (!aresetn)
      up_reg <= 3'h0;
    else if (up_reg != 3'h4)
      up_reg <= up_reg + 3'h1;
  end
  assign ok = (up_reg == 3'h4);
  // postscale code expected from the stored word, reserved codes clamped
  logic [4:0] exp_post;
  assign exp_post = (nv_wdog_word[20:16] > 5'h14) ? 5'h14
                    : nv_wdog_word[20:16];
  AST_WIN_SIZE: assert property (
    ok |-> wdog_window_size == nv_wdog_word[25:24])
    else $error("window size code differs from stored word");
  AST_HARD_EN: assert property (
    ok && nv_wdog_word[23] |-> wdog_enable)
    else $error("watchdog off although hard enable is set");
  AST_MODE: assert property (
    ok |-> wdog_window_mode == !nv_wdog_word[22])
    else $error("window mode does not follow window disable bit");
  AST_RATIO: assert property (
    ok |-> wdog_post_ratio == (21'h000001 << exp_post))
    else $error("postscale ratio is not two to the code");
  AST_POST_CLAMP: assert property (
    ok |-> wdog_postscale_sel == exp_post)
    else $error("postscale code not clamped to maximum");
  AST_BUS_PWR: assert property (
    ok |-> bus_power_pin_owner == nv_pin_word[31])
    else $error("bus power pin owner differs");
  AST_USB_ID: assert property (
    ok |-> usb_id_pin_owner == nv_pin_word[30])
    else $error("usb ident pin owner differs");
  AST_UID: assert property (
    ok |-> user_identifier == nv_pin_word[15:0])
    else $error("user identifier differs");
  AST_STATIC: assert property (
    ok && $past(ok) |-> $stable({wdog_window_size, wdog_window_mode,
    wdog_postscale_sel, wdog_post_ratio, bus_power_pin_owner,
    usb_id_pin_owner, user_identifier}))
    else $error("decoded setting moved");
endmodule
bind cfg_word_decoder cfg_word_decoder_props props_u (.aclk(aclk),
  .aresetn(aresetn), .nv_wdog_word(nv_wdog_word), .nv_pin_word(nv_pin_word),
  .wdog_window_size(wdog_window_size), .wdog_enable(wdog_enable),
  .wdog_window_mode(wdog_window_mode), .wdog_post_ratio(wdog_post_ratio),
  .wdog_postscale_sel(wdog_postscale_sel), .user_identifier(user_identifier),
  .bus_power_pin_owner(bus_power_pin_owner),
  .usb_id_pin_owner(usb_id_pin_owner));
`default_nettype wire

// file: bench/cfg_word_decoder_tb.sv
// self-checking bench: decode, locks and register bus of the word decoder.
// assumes the storage model is reprogrammed only inside do_reset.
`default_nettype none
module cfg_word_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] nv_w1, nv_w3, rdata;
  logic [31:0] wdata = 32'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, mode, en, busp, usb_ident_pin;
  logic [1:0] bresp, rresp, winsz;
  logic [4:0] post;
  logic [20:0] ratio;
  logic [15:0] pmap, moff, uid;
  int bad_count = 0;
  int tests_run = 0;
  always #25 aclk = ~aclk;
  cfg_nv_store_model nv_u (.wdog_word(nv_w1), .pin_word(nv_w3));
  cfg_word_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .nv_wdog_word(nv_w1),
    .nv_pin_word(nv_w3), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wdog_window_size(winsz), .wdog_enable(en),
    .wdog_window_mode(mode), .wdog_postscale_sel(post), .wdog_post_ratio(ratio),
    .bus_power_pin_owner(busp), .usb_id_pin_owner(usb_ident_pin), .pin_map(pmap),
    .module_off(moff), .user_identifier(uid));
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one comparison; narrow results arrive zero extended
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // the words only change under reset, so capture always sees them settled
  task automatic do_reset(input logic [31:0] w1, input logic [31:0] w3);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    nv_u.program_words(w1, w3);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 60 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid) begin
        done = 1;
        r = bresp;
        bready <= 1'h0;
      end
    end
    if (!done) begin
      bad_count++;
      stop_test();
    end
    // one edge passes so the next call never re-drives bready at once
    @(posedge aclk);
  endtask
  // read: rready held high from the start until rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 60 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid) begin
        done = 1;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
    end
    if (!done) begin
      bad_count++;
      stop_test();
    end
    // one edge passes so the next call never re-drives rready at once
    @(posedge aclk);
  endtask
  // every window code, out-of-range postscale codes, both owner settings
  task automatic sc_decode();
    logic [4:0] pc [4] = '{5'h00, 5'h14, 5'h15, 5'h1F};
    logic [31:0] w1, w3, d;
    logic [4:0] ep;
    logic [1:0] k, r;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      ep = (pc[i] > 5'h14) ? 5'h14 : pc[i];
      w1 = {6'h3F, k, k[0], k[1], 1'h1, pc[i], 16'hFFFF};
      w3 = {k[1], k[0], 14'h3FFF, 8'h5A, 6'h00, k};
      do_reset(w1, w3);
      chk(k, winsz);
      chk(k[0], en);
      chk(!k[1], mode);
      chk(ep, post);
      chk(32'h1 << ep, ratio);
      chk(k[1], busp);
      chk(k[0], usb_ident_pin);
      chk(w3[15:0], uid);
      rd(8'h04, d, r);
      chk(w3 & 32'hF000FFFF, d);
      rd(8'h00, d, r);
      chk(w1, d);
      rd(8'h08, d, r);
      chk({24'h000000, ep, ~k[1], k[0], 1'h1}, d);
    end
  endtask
  // software may switch the watchdog only while hard enable is clear
  task automatic sc_soft_en();
    logic [1:0] r;
    do_reset(32'hFF7FFFFF, 32'h0);
    wr(8'h0C, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk(1'h1, en);
    wr(8'h0C, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk(1'h0, en);
    do_reset(32'hFFFFFFFF, 32'h0);
    wr(8'h0C, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk(1'h1, en);
  endtask
  // second change of pin map and module disable, unlocked then locked
  task automatic sc_lock();
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? 8'h14 : 8'h10;
      do_reset(32'hFFFFFFFF, {2'h0, i[1], i[1], 28'h0});
      wr(a, 32'h1234, r);
      chk(2'h0, r);
      wr(a, 32'h5678, r);
      chk(i[1] ? 2'h2 : 2'h0, r);
      rd(a, d, r);
      chk(i[1] ? 32'h1234 : 32'h5678, d);
      chk(i[1] ? 16'h1234 : 16'h5678, i[0] ? moff : pmap);
      rd(8'h18, d, r);
      chk(i[0] ? 32'h2 : 32'h1, d);
    end
  endtask
  // unmapped places refuse, the stored image ignores writes
  task automatic sc_bus();
    logic [1:0] r;
    logic [31:0] d;
    rd(8'h3C, d, r);
    chk(2'h2, r);
    chk(32'h0, d);
    wr(8'h3C, 32'h1, r);
    chk(2'h2, r);
    wr(8'h00, 32'h0, r);
    chk(2'h0, r);
    rd(8'h00, d, r);
    chk(32'hFFFFFFFF, d);
  endtask
  initial begin
    sc_decode();
    sc_soft_en();
    sc_lock();
    sc_bus();
    stop_test();
  end
endmodule
`default_nettype wire
